// ==== lcl_top.sv ====
/*
  Call, count and supervision logic of a two-channel loop detector:
  paired-channel combining, count outputs with accumulators, event
  history, backlight hold timer, strength graph, inductance view, labels.
  Assumes det and sw come from pins; measurements, events and chan_rst
  come from logic on clk; software uses the plain register port.
*/
// Chosen here: the placing of the registers and the strobed register port.
// Behaviour
// - directional mode: last arriving channel holds call
// - both-occupied output only while both in call
// - counting mode pulses count output per vehicle
// - accumulator counts to 999999 then wraps
// - keep last 25 fault and power events
// - switch actuation lights backlight for two hours
// - store five-character alphanumeric channel label
// - strength graph advances only during call, six seconds
// - inductance reported within 20 to 2500 uH
// - percent inductance change shown during call
// - strength live during call, 10 is optimum
// - channel reset keeps history; only clear erases (the code also empties it on sys_rst)
module lcl_top
  import lcl_pkg::*;
#(
  parameter int STREAM_TICK = STREAM_TICK_CYC,
  parameter int COUNT_PW = COUNT_PW_CYC,
  parameter logic [39:0] BKLT_HOLD = BKLT_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [1:0] chan_rst,
  input wire logic [1:0] det,
  input wire logic [3:0] sw,
  input wire lcl_meas_t [1:0] meas,
  input wire logic [1:0] evt_vld,
  input wire logic [1:0][7:0] evt_code,
  input wire logic pwr_evt,
  input wire lcl_bus_t bus,
  output logic [31:0] rdata,
  output logic [1:0] call_out,
  output logic both_occupied_output,
  output logic [1:0] count_out,
  output logic backlight,
  output logic irq
);
  typedef struct packed {
    logic [1:0] det_s1;
    logic [1:0] det_s2;
    logic [1:0] det_q;
    logic [3:0] sw_s1;
    logic [3:0] sw_s2;
    logic [3:0] sw_q;
    lcl_pair_t pair;
    logic [1:0] cnt_en;
    logic last;
    logic [1:0] supp;
    logic [1:0] calls;
    logic both;
    logic [1:0] cnt_pulse;
    logic [1:0][22:0] pw_cnt;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic hsel_ch;
    logic [4:0] hsel_idx;
    logic rd_hist;
    logic hvld;
    logic [31:0] rdata;
    logic [39:0] bklt;
    logic [1:0][4:0] wp;
    logic [1:0][4:0] hcnt;
    logic [1:0][21:0] stick;
    logic [1:0][5:0] col;
    logic [1:0][7:0] samp;
    logic [1:0][7:0] strength;
    logic [1:0][11:0] induct;
    logic [1:0][15:0] dll;
    logic [1:0][LABEL_CHARS*8-1:0] label;
  } lcl_top_st_t;

  lcl_top_st_t s_ff, nxt_s;
  logic [1:0] cnt_start;
  logic [1:0] hist_we;
  logic [1:0][7:0] hist_wd;
  logic [1:0][4:0] hist_wa;
  logic [1:0][7:0] hist_q;
  logic [1:0][19:0] acc;
  logic [4:0] hist_raddr;

  // true when addr falls on a given word of channel ch's block
  function automatic logic ch_hit(input logic [7:0] addr, input logic ch,
                                  input logic [4:0] off);
    logic [7:0] base;
    base = A_CH_BASE + (ch ? A_CH_STRIDE : 8'h00);
    return addr == base + {3'h0, off};
  endfunction

  function automatic logic lab_ok(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h5a) ||
           (c >= 8'h61 && c <= 8'h7a) || c == LABEL_BLANK;
  endfunction

  // slot of the k-th newest entry; k = 0 is the most recent
  function automatic logic [4:0] hist_slot(input logic [4:0] wp, input logic [4:0] k);
    logic [5:0] t;
    t = {1'b0, wp} + 6'(HIST_DEPTH) - 6'h1 - {1'b0, k};
    if (t >= 6'(HIST_DEPTH)) begin
      t = t - 6'(HIST_DEPTH);
    end
    return t[4:0];
  endfunction

  assign hist_raddr = hist_slot(s_ff.wp[s_ff.hsel_ch], s_ff.hsel_idx);

  always_comb begin
    logic [1:0] d;
    logic [1:0] rise;
    logic [1:0] hclr;
    logic [ST_W-1:0] set;
    logic [ST_W-1:0] w1c;
    logic ok;
    d = s_ff.det_s2;
    rise = s_ff.det_s2 & ~s_ff.det_q;
    hclr = 2'h0;
    set = '0;
    w1c = '0;
    ok = 1'b0;
    nxt_s = s_ff;
    nxt_s.det_s1 = det;
    nxt_s.det_s2 = s_ff.det_s1;
    nxt_s.det_q = s_ff.det_s2;
    nxt_s.sw_s1 = sw;
    nxt_s.sw_s2 = s_ff.sw_s1;
    nxt_s.sw_q = s_ff.sw_s2;

    // paired channels; a late arrival wins the pair
    if (rise[1]) begin
      nxt_s.last = 1'b1;
    end else if (rise[0]) begin
      nxt_s.last = 1'b0;
    end
    for (int i = 0; i < 2; i++) begin
      if (!d[i] || s_ff.pair != PAIR_DIR) begin
        nxt_s.supp[i] = 1'b0;
      end else if (d == 2'b11 && nxt_s.last != 1'(i)) begin
        nxt_s.supp[i] = 1'b1;
      end
      // first arrival stays quiet until its own detection ends
      nxt_s.calls[i] = d[i] & ~nxt_s.supp[i];
    end
    nxt_s.both = (s_ff.pair == PAIR_BOTH) && nxt_s.calls == 2'b11;

    for (int i = 0; i < 2; i++) begin
      // count output
      cnt_start[i] = s_ff.cnt_en[i] & rise[i];
      if (cnt_start[i]) begin
        nxt_s.cnt_pulse[i] = 1'b1;
        nxt_s.pw_cnt[i] = 23'(COUNT_PW - 1);
      end else if (s_ff.pw_cnt[i] != 23'h0) begin
        nxt_s.pw_cnt[i] = s_ff.pw_cnt[i] - 23'h1;
      end else begin
        nxt_s.cnt_pulse[i] = 1'b0;
      end
      set[ST_CNT0 + i] = cnt_start[i];

      // streaming graph stalls outside a call
      if (s_ff.calls[i]) begin
        if (s_ff.stick[i] >= 22'(STREAM_TICK - 1)) begin
          nxt_s.stick[i] = 22'h0;
          nxt_s.col[i] = s_ff.col[i] + 6'h1;
          nxt_s.samp[i] = meas[i].strength;
        end else begin
          nxt_s.stick[i] = s_ff.stick[i] + 22'h1;
        end
      end

      // live views
      nxt_s.strength[i] = meas[i].strength;
      if (meas[i].induct_uh < INDUCT_MIN_UH) begin
        nxt_s.induct[i] = INDUCT_MIN_UH;
      end else if (meas[i].induct_uh > INDUCT_MAX_UH) begin
        nxt_s.induct[i] = INDUCT_MAX_UH;
      end else begin
        nxt_s.induct[i] = meas[i].induct_uh;
      end
      nxt_s.dll[i] = s_ff.calls[i] ? meas[i].dll : 16'h0;

      // channel reset clears call state but not the history
      if (chan_rst[i]) begin
        nxt_s.supp[i] = 1'b0;
        nxt_s.calls[i] = 1'b0;
        nxt_s.cnt_pulse[i] = 1'b0;
        nxt_s.pw_cnt[i] = 23'h0;
        nxt_s.stick[i] = 22'h0;
        nxt_s.col[i] = 6'h0;
      end
    end
    nxt_s.both = nxt_s.both & (chan_rst == 2'h0);

    // backlight hold, restarted by any switch change
    if ((s_ff.sw_s2 ^ s_ff.sw_q) != 4'h0) begin
      nxt_s.bklt = BKLT_HOLD;
    end else if (s_ff.bklt != 40'h0) begin
      nxt_s.bklt = s_ff.bklt - 40'h1;
    end

    // register writes
    if (bus.wr) begin
      unique case (bus.addr)
        A_CTRL: begin
          nxt_s.pair = (bus.wdata[F_PAIR +: 2] == 2'h3) ? PAIR_NONE
                       : lcl_pair_t'(bus.wdata[F_PAIR +: 2]);
          nxt_s.cnt_en = bus.wdata[F_CNTEN +: 2];
        end
        A_STAT: w1c = bus.wdata[ST_W-1:0];
        A_MASK: nxt_s.mask = bus.wdata[ST_W-1:0];
        A_CMD: hclr = bus.wdata[1:0];
        A_HSEL: begin
          nxt_s.hsel_idx = bus.wdata[4:0];
          nxt_s.hsel_ch = bus.wdata[F_HSEL_CH];
        end
        default: begin
          for (int i = 0; i < 2; i++) begin
            if (ch_hit(bus.addr, 1'(i), O_LAB_LO)) begin
              ok = 1'b1;
              for (int b = 0; b < 4; b++) begin
                ok = ok & lab_ok(bus.wdata[b*8 +: 8]);
              end
              // a label word with an illegal character is refused whole
              if (ok) begin
                nxt_s.label[i][31:0] = bus.wdata;
              end
            end
            if (ch_hit(bus.addr, 1'(i), O_LAB_HI) && lab_ok(bus.wdata[7:0])) begin
              nxt_s.label[i][39:32] = bus.wdata[7:0];
            end
          end
        end
      endcase
    end

    // history ring; clear first so an event in the same cycle survives
    for (int i = 0; i < 2; i++) begin
      hist_we[i] = evt_vld[i] | pwr_evt;
      hist_wd[i] = evt_vld[i] ? evt_code[i] : PWR_CODE;
      if (hclr[i]) begin
        nxt_s.wp[i] = 5'h0;
        nxt_s.hcnt[i] = 5'h0;
      end
      hist_wa[i] = hclr[i] ? 5'h0 : s_ff.wp[i];
      if (hist_we[i]) begin
        nxt_s.wp[i] = (nxt_s.wp[i] == 5'(HIST_DEPTH - 1)) ? 5'h0 : nxt_s.wp[i] + 5'h1;
        if (nxt_s.hcnt[i] != 5'(HIST_DEPTH)) begin
          nxt_s.hcnt[i] = nxt_s.hcnt[i] + 5'h1;
        end
      end
      set[ST_FLT0 + i] = evt_vld[i];
    end
    set[ST_PWR] = pwr_evt;
    nxt_s.status = (s_ff.status & ~w1c) | set;

    // register reads
    nxt_s.rd_hist = bus.rd && bus.addr == A_HDAT;
    nxt_s.hvld = s_ff.hsel_idx < s_ff.hcnt[s_ff.hsel_ch];
    nxt_s.rdata = 32'h0;
    if (bus.rd) begin
      unique case (bus.addr)
        A_CTRL: nxt_s.rdata = {28'h0, s_ff.cnt_en, s_ff.pair};
        A_STAT: nxt_s.rdata = {27'h0, s_ff.status};
        A_MASK: nxt_s.rdata = {27'h0, s_ff.mask};
        A_HSEL: nxt_s.rdata = {23'h0, s_ff.hsel_ch, 3'h0, s_ff.hsel_idx};
        A_CALLS: nxt_s.rdata = {6'h0, s_ff.hcnt[1], 3'h0, s_ff.hcnt[0],
                                5'h0, s_ff.bklt != 40'h0, s_ff.cnt_pulse,
                                s_ff.both, s_ff.calls, d};
        default: begin
          for (int i = 0; i < 2; i++) begin
            if (ch_hit(bus.addr, 1'(i), O_ACC)) begin
              nxt_s.rdata = {12'h0, acc[i]};
            end
            if (ch_hit(bus.addr, 1'(i), O_GRAPH)) begin
              nxt_s.rdata = {s_ff.samp[i], 2'h0, s_ff.col[i], 7'h0,
                             s_ff.strength[i] >= OPT_STRENGTH, s_ff.strength[i]};
            end
            if (ch_hit(bus.addr, 1'(i), O_INDUCT)) begin
              nxt_s.rdata = {20'h0, s_ff.induct[i]};
            end
            if (ch_hit(bus.addr, 1'(i), O_DLL)) begin
              nxt_s.rdata = {16'h0, s_ff.dll[i]};
            end
            if (ch_hit(bus.addr, 1'(i), O_LAB_LO)) begin
              nxt_s.rdata = s_ff.label[i][31:0];
            end
            if (ch_hit(bus.addr, 1'(i), O_LAB_HI)) begin
              nxt_s.rdata = {24'h0, s_ff.label[i][39:32]};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_ff <= '0;
      s_ff.label <= {2{{LABEL_CHARS{LABEL_BLANK}}}};
    end else begin
      s_ff <= nxt_s;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_ch
    lcl_hist_mem u_mem (
      .clk(clk),
      .we(hist_we[g]),
      .waddr(hist_wa[g]),
      .wdata(hist_wd[g]),
      .raddr(hist_raddr),
      .rdata(hist_q[g])
    );
    lcl_vcount u_acc (
      .clk(clk),
      .sys_rst(sys_rst),
      .clr(chan_rst[g]),
      .inc(cnt_start[g]),
      .value(acc[g])
    );
  end

  // history word comes straight from the memory register
  assign rdata = s_ff.rd_hist ? {23'h0, s_ff.hvld, hist_q[s_ff.hsel_ch]} : s_ff.rdata;
  assign call_out = s_ff.calls;
  assign both_occupied_output = s_ff.both;
  assign count_out = s_ff.cnt_pulse;
  assign backlight = s_ff.bklt != 40'h0;
  assign irq = (s_ff.status & s_ff.mask) != '0;
endmodule

// ==== lcl_pkg.sv ====
/*
  Shared constants and types for the loop detector call logic:
  register offsets, field positions, reset values, timing counts.
  Assumes a single 40 MHz clock and a plain strobe register port.
*/
package lcl_pkg;
  localparam int CLK_HZ = 40_000_000;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_MASK = 8'h08;
  localparam logic [7:0] A_CMD = 8'h0c;
  localparam logic [7:0] A_HSEL = 8'h10;
  localparam logic [7:0] A_HDAT = 8'h14;
  localparam logic [7:0] A_CALLS = 8'h18;
  localparam logic [7:0] A_CH_BASE = 8'h20;
  localparam logic [7:0] A_CH_STRIDE = 8'h20;
  // offsets inside a channel block
  localparam logic [4:0] O_ACC = 5'h00;
  localparam logic [4:0] O_GRAPH = 5'h04;
  localparam logic [4:0] O_INDUCT = 5'h08;
  localparam logic [4:0] O_DLL = 5'h0c;
  localparam logic [4:0] O_LAB_LO = 5'h10;
  localparam logic [4:0] O_LAB_HI = 5'h14;
  // field positions
  localparam int F_PAIR = 0;
  localparam int F_CNTEN = 2;
  localparam int F_HSEL_CH = 8;
  // status bit positions
  localparam int ST_FLT0 = 0;
  localparam int ST_CNT0 = 2;
  localparam int ST_PWR = 4;
  localparam int ST_W = 5;
  // figures of the block
  localparam logic [19:0] ACC_MAX = 20'd999999;
  localparam int HIST_DEPTH = 25;
  localparam int HIST_WORDS = 32;
  localparam logic [7:0] PWR_CODE = 8'hf0;
  localparam logic [11:0] INDUCT_MIN_UH = 12'd20;
  localparam logic [11:0] INDUCT_MAX_UH = 12'd2500;
  localparam logic [7:0] OPT_STRENGTH = 8'd10;
  localparam int LABEL_CHARS = 5;
  localparam logic [7:0] LABEL_BLANK = 8'h20;
  // times and derived cycle counts
  localparam int BKLT_HOURS = 2;
  localparam logic [39:0] BKLT_CYC =
    40'(64'(BKLT_HOURS) * 64'd3600 * 64'(CLK_HZ));
  localparam int STREAM_SPAN_S = 6;
  localparam int STREAM_COLS = 64;
  localparam int STREAM_TICK_CYC = (CLK_HZ / STREAM_COLS) * STREAM_SPAN_S;
  localparam int COUNT_PW_MS = 125;
  localparam int COUNT_PW_CYC = (CLK_HZ / 1000) * COUNT_PW_MS;

  typedef enum logic [1:0] {PAIR_NONE, PAIR_DIR, PAIR_BOTH} lcl_pair_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } lcl_bus_t;

  typedef struct packed {
    logic [7:0] strength;
    logic [11:0] induct_uh;
    logic [15:0] dll;
  } lcl_meas_t;

  typedef struct packed {
    logic [19:0] value;
  } lcl_acc_t;

  typedef struct packed {
    logic [HIST_WORDS-1:0][7:0] word;
    logic [7:0] q;
  } lcl_mem_t;
endpackage

// ==== lcl_hist_mem.sv ====
/*
  Event history storage for one channel: 32 words of 8 bits,
  one write port, read data from a register one cycle after the address.
  Assumes the caller keeps the ring pointers.
*/
module lcl_hist_mem
  import lcl_pkg::*;
(
  input wire logic clk,
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [4:0] raddr,
  output logic [7:0] rdata
);
  lcl_mem_t s_ff, nxt_s;

  // contents are not reset; a restart still empties the log since lcl_top zeroes hcnt and wp
  always_comb begin
    nxt_s = s_ff;
    nxt_s.q = s_ff.word[raddr];
    if (we) begin
      nxt_s.word[waddr] = wdata;
    end
  end

  always_ff @(posedge clk) begin
    s_ff <= nxt_s;
  end

  assign rdata = s_ff.q;
endmodule

// ==== lcl_vcount.sv ====
/*
  Six-digit vehicle accumulator for one channel.
  Assumes inc is a one-cycle pulse per count event.
*/
module lcl_vcount
  import lcl_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clr,
  input wire logic inc,
  output logic [19:0] value
);
  lcl_acc_t s_ff, nxt_s;

  always_comb begin
    nxt_s = s_ff;
    if (clr) begin
      nxt_s.value = 20'h0;
    end else if (inc) begin
      nxt_s.value = (s_ff.value == ACC_MAX) ? 20'h0 : s_ff.value + 20'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign value = s_ff.value;
endmodule

// ==== lcl_top_asserts.sv ====
/*
  Concurrent checks on the ports of lcl_top, bound into every instance.
  Assumes one clock, synchronous active-high reset, and that the count
  pulse is never cut short by a channel reset while it stands.
*/
module lcl_top_chk
  import lcl_pkg::*;
#(
  parameter int COUNT_PW = COUNT_PW_CYC,
  parameter logic [39:0] BKLT_HOLD = BKLT_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [1:0] det,
  input wire logic [3:0] sw,
  input wire lcl_bus_t bus,
  input wire logic [31:0] rdata,
  input wire logic [1:0] call_out,
  input wire logic both_occupied_output,
  input wire logic [1:0] count_out,
  input wire logic backlight
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] run_ff;
  logic [39:0] idle_ff;
  logic [3:0] sw_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // idle saturates so a long quiet spell never looks like a fresh actuation
  always_ff @(posedge clk) begin
    run_ff <= count_out[0] ? run_ff + 32'h1 : 32'h0;
    sw_ff <= sw;
    if (sys_rst) idle_ff <= '1;
    else if (sw != sw_ff) idle_ff <= '0;
    else if (idle_ff != '1) idle_ff <= idle_ff + 40'h1;
  end
  a_both_needs_calls: assert property (both_occupied_output |-> call_out == 2'b11)
    else $error("both output without two calls");
  a_call_has_det: assert property (call_out[1] |->
    |{$past(det[1]), $past(det[1], 2), $past(det[1], 3), $past(det[1], 4)})
    else $error("call without detection");
  a_count_has_det: assert property ($rose(count_out[0]) |->
    |{$past(det[0]), $past(det[0], 2), $past(det[0], 3), $past(det[0], 4)})
    else $error("count pulse without arrival");
  a_count_width: assert property ($fell(count_out[0]) |-> run_ff >= COUNT_PW)
    else $error("count pulse too short");
  a_bklt_lights: assert property (sw != $past(sw) |-> ##[1:4] backlight)
    else $error("backlight not lit by switch");
  a_bklt_early_off: assert property ($fell(backlight) |-> idle_ff >= BKLT_HOLD)
    else $error("backlight dropped early");
  a_bklt_late_off: assert property (backlight |-> idle_ff <= BKLT_HOLD + 40'h6)
    else $error("backlight held too long");
  a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
    else $error("read data outside read cycle");
endmodule

bind lcl_top lcl_top_chk #(.COUNT_PW(COUNT_PW), .BKLT_HOLD(BKLT_HOLD)) lcl_top_chk_i (
  .clk(clk), .sys_rst(sys_rst), .det(det), .sw(sw), .bus(bus), .rdata(rdata),
  .call_out(call_out), .both_occupied_output(both_occupied_output),
  .count_out(count_out), .backlight(backlight));

// ==== lcl_ctrl_model.sv ====
/*
  Traffic controller stand-in: tallies vehicles from the count outputs.
  Assumes count pulses are at least one clock wide and clocked on clk.
*/
module lcl_ctrl_model
  import lcl_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [1:0] count_out,
  output logic [1:0][15:0] n_veh
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] prev_ff;
  // one vehicle per rising edge, so a long pulse is never counted twice
  always_ff @(posedge clk) begin
    prev_ff <= count_out;
    for (int c = 0; c < 2; c++) begin
      if (sys_rst) n_veh[c] <= 16'h0;
      else if (count_out[c] && !prev_ff[c]) n_veh[c] <= n_veh[c] + 16'h1;
    end
  end
endmodule

// ==== lcl_top_bench.sv ====
/*
  Self-checking bench for lcl_top with short timing parameters.
  Assumes the checker bind and the controller model are compiled first.
*/
module lcl_top_bench
  import lcl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CH = A_CH_BASE;
  localparam logic [7:0] LLO = A_CH_BASE + 8'(O_LAB_LO);
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] chan_rst = '0, det = '0, evt_vld = '0;
  logic [3:0] sw = '0;
  lcl_meas_t [1:0] meas = '0;
  logic [1:0][7:0] evt_code = '0;
  logic pwr_evt = 1'b0;
  lcl_bus_t bus = '0;
  logic [31:0] rdata, d, c1;
  logic [1:0] call_out, count_out;
  logic both_occupied_output, backlight, irq;
  logic [1:0][15:0] n_veh;
  int miscompares = 0, n_compared = 0, cyc = 0;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
  always #12.5 clk = ~clk;
  lcl_top #(.STREAM_TICK(8), .COUNT_PW(4), .BKLT_HOLD(40'h14)) lcl_top_i (
    .clk(clk), .sys_rst(sys_rst), .chan_rst(chan_rst), .det(det), .sw(sw),
    .meas(meas), .evt_vld(evt_vld), .evt_code(evt_code), .pwr_evt(pwr_evt),
    .bus(bus), .rdata(rdata), .call_out(call_out),
    .both_occupied_output(both_occupied_output), .count_out(count_out),
    .backlight(backlight), .irq(irq));
  lcl_ctrl_model lcl_ctrl_model_i (.clk(clk), .sys_rst(sys_rst),
    .count_out(count_out), .n_veh(n_veh));
  task automatic wt(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic hq(logic [31:0] sel);
    wr(A_HSEL, sel);
    rd(A_HDAT);
  endtask
  task automatic pulse_rst();
    @(posedge clk) chan_rst <= 2'b01;
    @(posedge clk) chan_rst <= 2'b00;
    wt(2);
  endtask
  task automatic t_label();
    rd(LLO);
    `CHK(d, 32'h20202020)
    wr(LLO, 32'h34333231);
    wr(LLO + 8'h04, 32'h00000035);
    wr(LLO, 32'h2a333231);
    rd(LLO);
    `CHK(d, 32'h34333231)
    rd(LLO + 8'h04);
    `CHK(d[7:0], 8'h35)
    rd(8'h1c);
    `CHK(d, 32'h0)
    $display("label test done");
  endtask
  task automatic t_pair();
    wr(A_CTRL, 32'h1);
    @(posedge clk) det <= 2'b01;
    wt(6);
    @(posedge clk) det <= 2'b11;
    wt(6);
    `CHK(call_out, 2'b10)
    @(posedge clk) det <= 2'b10;
    wt(6);
    `CHK(call_out, 2'b10)
    @(posedge clk) det <= 2'b00;
    wt(6);
    wr(A_CTRL, 32'h2);
    @(posedge clk) det <= 2'b11;
    wt(6);
    `CHK(both_occupied_output, 1'b1)
    @(posedge clk) det <= 2'b10;
    wt(5);
    `CHK(both_occupied_output, 1'b0)
    @(posedge clk) det <= 2'b00;
    $display("pair test done");
  endtask
  task automatic t_count();
    wr(A_CTRL, 32'h4);
    repeat (3) begin
      @(posedge clk) det <= 2'b01;
      wt(8);
      @(posedge clk) det <= 2'b00;
      wt(8);
    end
    `CHK(n_veh[0], 16'h3)
    rd(CH + 8'(O_ACC));
    `CHK(d, 32'h3)
    rd(A_STAT);
    `CHK(d[ST_CNT0], 1'b1)
    wr(A_MASK, 32'h4);
    wt(2);
    `CHK(irq, 1'b1)
    wr(A_STAT, 32'h4);
    wt(2);
    `CHK(irq, 1'b0)
    pulse_rst();
    rd(CH + 8'(O_ACC));
    `CHK(d, 32'h0)
    $display("count test done");
  endtask
  task automatic t_hist();
    for (int i = 1; i <= 27; i++) begin
      @(posedge clk) evt_vld <= 2'b01;
      evt_code[0] <= 8'(i);
      @(posedge clk) evt_vld <= 2'b00;
    end
    rd(A_CALLS);
    `CHK(d[17:13], 5'h19)
    hq(32'h0);
    `CHK(d[8:0], 9'h11b)
    hq(32'h18);
    `CHK(d[8:0], 9'h103)
    hq(32'h19);
    `CHK(d[8], 1'b0)
    pulse_rst();
    rd(A_CALLS);
    `CHK(d[17:13], 5'h19)
    // clear and a power event land on the same edge; the event must survive
    fork
      wr(A_CMD, 32'h1);
      begin
        @(posedge clk) pwr_evt <= 1'b1;
        @(posedge clk) pwr_evt <= 1'b0;
      end
    join
    rd(A_CALLS);
    `CHK(d[17:13], 5'h1)
    hq(32'h0);
    `CHK(d[8:0], {1'b1, PWR_CODE})
    hq(32'h100);
    `CHK(d[8:0], {1'b1, PWR_CODE})
    $display("history test done");
  endtask
  task automatic t_bklt();
    @(posedge clk) sw <= 4'h1;
    wt(14);
    `CHK(backlight, 1'b1)
    @(posedge clk) sw <= 4'h0;
    wt(15);
    `CHK(backlight, 1'b1)
    wt(15);
    `CHK(backlight, 1'b0)
    $display("backlight test done");
  endtask
  task automatic t_meas();
    wr(A_CTRL, 32'h3);
    rd(A_CTRL);
    `CHK(d, 32'h0)
    @(posedge clk) meas[0] <= {8'h0a, 12'h005, 16'h0123};
    rd(CH + 8'(O_INDUCT));
    `CHK(d, 32'h14)
    rd(CH + 8'(O_DLL));
    `CHK(d, 32'h0)
    rd(CH + 8'(O_GRAPH));
    `CHK(d[8:0], 9'h10a)
    c1 = d;
    wt(40);
    rd(CH + 8'(O_GRAPH));
    `CHK(d[21:16], c1[21:16])
    @(posedge clk) meas[0] <= {8'h09, 12'hbb8, 16'h0123};
    det <= 2'b01;
    wt(6);
    rd(CH + 8'(O_INDUCT));
    `CHK(d, 32'h9c4)
    rd(CH + 8'(O_DLL));
    `CHK(d, 32'h0123)
    rd(CH + 8'(O_GRAPH));
    `CHK(d[8:0], 9'h009)
    c1 = d;
    wt(40);
    rd(CH + 8'(O_GRAPH));
    `CHK(d[21:16] != c1[21:16], 1'b1)
    @(posedge clk) det <= 2'b00;
    $display("measure test done");
  endtask
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // generous ceiling: the whole sequence needs well under two thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_label();
    t_pair();
    t_count();
    t_hist();
    t_bklt();
    t_meas();
    conclude();
  end
endmodule
